/* File: shared/twse_regs.vh */
// Constants for the two-wire serial engine: status codes, timing counts, sizes
`ifndef TWSE_REGS_VH
`define TWSE_REGS_VH

// Clock period and spike window, in ns
`define TWSE_CLK_NS      5
`define TWSE_SPIKE_NS    50
// Least stable time rounds up to whole clock cycles
`define TWSE_FILT_CYC    ((`TWSE_SPIKE_NS + `TWSE_CLK_NS - 1) / `TWSE_CLK_NS)

// Fixed part of each SCL half period, in clocks
`define TWSE_HALF_BASE   16'h0008

// Receive buffer depth
`define TWSE_BUF_DEPTH   2'h2

// Status codes, upper five bits significant
`define TWSE_ST_IDLE     8'hF8
`define TWSE_ST_BUS_ERR  8'h00
`define TWSE_ST_START    8'h08
`define TWSE_ST_RSTART   8'h10
`define TWSE_ST_MT_SLA_A 8'h18
`define TWSE_ST_MT_SLA_N 8'h20
`define TWSE_ST_MT_DAT_A 8'h28
`define TWSE_ST_MT_DAT_N 8'h30
`define TWSE_ST_ARB_LOST 8'h38
`define TWSE_ST_MR_SLA_A 8'h40
`define TWSE_ST_MR_SLA_N 8'h48
`define TWSE_ST_MR_DAT_A 8'h50
`define TWSE_ST_MR_DAT_N 8'h58
`define TWSE_ST_SR_SLA   8'h60
`define TWSE_ST_SR_GC    8'h70
`define TWSE_ST_SR_DAT_A 8'h80
`define TWSE_ST_SR_DAT_N 8'h88
`define TWSE_ST_SR_STOP  8'hA0
`define TWSE_ST_ST_SLA   8'hA8
`define TWSE_ST_ST_DAT_A 8'hB8
`define TWSE_ST_ST_DAT_N 8'hC0

`endif

/* File: logic/twse_buf2.v */
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "twse_regs.vh"

module twse_buf2 (
  input  wire       ref_clk_i,
  input  wire       srst_i,
  input  wire       in_valid_i,
  input  wire [7:0] in_data_i,
  output wire       in_ready_o,
  output wire       out_valid_o,
  input  wire       out_ready_i,
  output wire [7:0] out_data_o
);

  reg  [7:0] mem_reg [0:1];
  reg        wptr_reg;
  reg        rptr_reg;
  reg  [1:0] cnt_reg;
  wire       push;
  wire       pop;

  // Full and empty straight from the fill count
  assign in_ready_o  = (cnt_reg != `TWSE_BUF_DEPTH);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = mem_reg[rptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage is not reset; the count alone says what is valid
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill count
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg  <= 2'h0;
    end else begin
      if (push) begin
        wptr_reg <= ~wptr_reg;
      end
      if (pop) begin
        rptr_reg <= ~rptr_reg;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 2'h1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end

endmodule

/* File: logic/twse_engine.v */
// Byte-oriented two-wire serial engine: master and slave, spike filter, status
`timescale 1ns/100ps
`include "twse_regs.vh"

module twse_engine (
  input  wire       ref_clk_i,
  input  wire       srst_i,
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire       enable_i,
  input  wire       start_req_i,
  input  wire       ack_en_i,
  input  wire       gc_enable_i,
  input  wire [6:0] own_addr_i,
  input  wire [7:0] bit_rate_divider_i,
  input  wire [1:0] prescale_i,
  input  wire       serial_irq_enable_i,
  input  wire       global_irq_i,
  input  wire       stop_set_i,
  input  wire       flag_clear_i,
  input  wire       data_wr_i,
  input  wire [7:0] data_i,
  output wire       op_complete_flag_o,
  output wire       stop_request_o,
  output wire [7:0] serial_status_o,
  output wire [7:0] serial_data_o,
  output wire       irq_o,
  output wire       bus_busy_o,
  output wire       rx_valid_o,
  input  wire       rx_ready_i,
  output wire [7:0] rx_data_o
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_BYTE  = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_START = 3'h3;
  localparam [2:0] ST_STOP  = 3'h4;
  localparam integer FILT_CYC  = `TWSE_FILT_CYC;
  localparam [3:0] FILT_LAST = FILT_CYC[3:0] - 4'h1;

  reg  [2:0]  state_reg;
  reg  [1:0]  ph_reg;
  reg  [15:0] tmr_reg;
  reg  [3:0]  bitcnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  data_reg;
  reg  [7:0]  code_reg;
  reg         arm_reg;
  reg         first_reg;
  reg         tx_reg;
  reg         mst_reg;
  reg         addr_reg;
  reg         gc_reg;
  reg         ack_reg;
  reg         rsta_reg;
  reg         err_reg;
  reg         idle_after_reg;
  reg         flag_reg;
  reg         stop_req_reg;
  reg         busy_reg;
  reg         scl_oe_reg;
  reg         sda_oe_reg;
  reg         scl_q_reg;
  reg         sda_q_reg;
  wire [1:0]  pin_in;
  wire [1:0]  filt;
  wire [15:0] half_w;
  wire        tmr_done;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        adr_own;
  wire        adr_gc;
  wire        byte_end;
  wire        rxb_valid;
  wire        rxb_ready;
  wire [7:0]  end_code;

  //////////////////////////////////////////////////////////////////////////
  // Input stage: two-flop synchroniser, then a stability filter per line
  assign pin_in = {scl_i, sda_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      reg       meta_reg;
      reg       sync_reg;
      reg       out_reg;
      reg [3:0] cnt_reg;
      always @(posedge ref_clk_i) begin
        if (srst_i) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          out_reg  <= 1'b1;
          cnt_reg  <= 4'h0;
        end else begin
          meta_reg <= pin_in[gi];
          sync_reg <= meta_reg;
          if (sync_reg == out_reg) begin
            cnt_reg <= 4'h0;
          end else if (cnt_reg == FILT_LAST) begin
            out_reg <= sync_reg;   // Level held for the whole window
            cnt_reg <= 4'h0;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
      end
      assign filt[gi] = out_reg;
    end
  endgenerate

  // Bus conditions seen on the filtered lines
  assign scl_rise  = filt[1] & ~scl_q_reg;
  assign scl_fall  = ~filt[1] & scl_q_reg;
  assign start_det = filt[1] & scl_q_reg & sda_q_reg & ~filt[0];
  assign stop_det  = filt[1] & scl_q_reg & ~sda_q_reg & filt[0];

  //////////////////////////////////////////////////////////////////////////
  // half period from divider and prescaler
  assign half_w   = `TWSE_HALF_BASE + ({8'h00, bit_rate_divider_i} << {prescale_i, 1'b0});
  assign tmr_done = (tmr_reg == half_w - 16'h0001);

  // Slave address decode on the completed address byte
  assign adr_own = enable_i & (shift_reg[7:1] == own_addr_i);
  assign adr_gc  = enable_i & gc_enable_i & (shift_reg[7:0] == 8'h00);

  // Byte finished and SCL parked low
  assign byte_end = (state_reg == ST_BYTE) & (bitcnt_reg == 4'h9);

  // Received data bytes enter the buffer; address bytes do not
  assign rxb_valid = byte_end & ~tx_reg & ~first_reg;

  // Status of a finished byte, chosen by role, phase and acknowledge
  assign end_code =
    mst_reg ?
      (first_reg ?
        (shift_reg[0] ? (ack_reg ? `TWSE_ST_MR_SLA_A : `TWSE_ST_MR_SLA_N)
                      : (ack_reg ? `TWSE_ST_MT_SLA_A : `TWSE_ST_MT_SLA_N))
      : tx_reg ? (ack_reg ? `TWSE_ST_MT_DAT_A : `TWSE_ST_MT_DAT_N)
               : (ack_reg ? `TWSE_ST_MR_DAT_A : `TWSE_ST_MR_DAT_N))
    : first_reg ? (gc_reg ? `TWSE_ST_SR_GC
                          : (shift_reg[0] ? `TWSE_ST_ST_SLA : `TWSE_ST_SR_SLA))
    : tx_reg ? (ack_reg ? `TWSE_ST_ST_DAT_A : `TWSE_ST_ST_DAT_N)
             : (ack_reg ? `TWSE_ST_SR_DAT_A : `TWSE_ST_SR_DAT_N);

  //////////////////////////////////////////////////////////////////////////
  // Main sequencer; later assignments in the block take priority
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg      <= ST_IDLE;
      ph_reg         <= 2'h0;
      tmr_reg        <= 16'h0000;
      bitcnt_reg     <= 4'h0;
      shift_reg      <= 8'h00;
      data_reg       <= 8'hFF;
      code_reg       <= `TWSE_ST_IDLE;
      arm_reg        <= 1'b0;
      first_reg      <= 1'b0;
      tx_reg         <= 1'b0;
      mst_reg        <= 1'b0;
      addr_reg       <= 1'b0;
      gc_reg         <= 1'b0;
      ack_reg        <= 1'b0;
      rsta_reg       <= 1'b0;
      err_reg        <= 1'b0;
      idle_after_reg <= 1'b0;
      flag_reg       <= 1'b0;
      stop_req_reg   <= 1'b0;
      busy_reg       <= 1'b0;
      scl_oe_reg     <= 1'b0;
      sda_oe_reg     <= 1'b0;
      scl_q_reg      <= 1'b1;
      sda_q_reg      <= 1'b1;
    end else begin
      scl_q_reg <= filt[1];
      sda_q_reg <= filt[0];
      if (start_det) begin
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        busy_reg <= 1'b0;
      end
      if (stop_set_i) begin
        stop_req_reg <= 1'b1;
      end
      if (data_wr_i) begin
        data_reg <= data_i;
      end
      // write one clears; a set later in this block wins
      // idle code whenever the flag is down
      if (flag_clear_i) begin
        flag_reg <= 1'b0;
        code_reg <= `TWSE_ST_IDLE;
      end

      case (state_reg)
        ST_IDLE: begin
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
          if (enable_i & start_req_i & ~busy_reg & ~flag_reg) begin
            mst_reg   <= 1'b1;
            rsta_reg  <= 1'b0;
            ph_reg    <= 2'h1;   // SCL already high on a free bus
            tmr_reg   <= 16'h0000;
            state_reg <= ST_START;
          end else if (enable_i & start_det) begin
            mst_reg    <= 1'b0;
            tx_reg     <= 1'b0;
            first_reg  <= 1'b1;
            arm_reg    <= 1'b1;  // Skip the SCL fall that ends the START
            bitcnt_reg <= 4'h0;
            state_reg  <= ST_BYTE;
          end
        end

        ST_START: begin
          tmr_reg <= tmr_reg + 16'h0001;
          if (ph_reg == 2'h0) begin
            // Repeated START: SDA up while SCL low, then SCL up
            sda_oe_reg <= 1'b0;
            if (tmr_done) begin
              scl_oe_reg <= 1'b0;
              tmr_reg    <= 16'h0000;
              ph_reg     <= 2'h1;
            end
          end else if (ph_reg == 2'h1) begin
            if (~filt[1]) begin
              tmr_reg <= 16'h0000;   // Another device stretches SCL
            end else if (tmr_done) begin
              sda_oe_reg <= 1'b1;
              tmr_reg    <= 16'h0000;
              ph_reg     <= 2'h2;
            end
          end else if (tmr_done) begin
            scl_oe_reg     <= 1'b1;
            flag_reg       <= 1'b1;
            code_reg       <= rsta_reg ? `TWSE_ST_RSTART : `TWSE_ST_START;
            first_reg      <= 1'b1;
            tx_reg         <= 1'b1;
            idle_after_reg <= 1'b0;
            state_reg      <= ST_WAIT;
          end
        end

        ST_STOP: begin
          tmr_reg <= tmr_reg + 16'h0001;
          if (ph_reg == 2'h0) begin
            if (tmr_done) begin
              scl_oe_reg <= 1'b0;
              tmr_reg    <= 16'h0000;
              ph_reg     <= 2'h1;
            end
          end else if (ph_reg == 2'h1) begin
            if (~filt[1]) begin
              tmr_reg <= 16'h0000;
            end else if (tmr_done) begin
              sda_oe_reg <= 1'b0;    // SDA rises while SCL high
              tmr_reg    <= 16'h0000;
              ph_reg     <= 2'h2;
            end
          end else if (tmr_done) begin
            mst_reg      <= 1'b0;
            stop_req_reg <= 1'b0;
            state_reg    <= ST_IDLE;
          end
        end

        ST_WAIT: begin
          // nothing moves until software clears the flag
          if (flag_clear_i) begin
            tmr_reg <= 16'h0000;
            if (err_reg | idle_after_reg | ~enable_i) begin
              // let go of both lines, no STOP on the bus
              scl_oe_reg <= 1'b0;
              sda_oe_reg <= 1'b0;
              mst_reg    <= 1'b0;
              addr_reg   <= 1'b0;
              err_reg    <= 1'b0;
              state_reg  <= ST_IDLE;
              // only recovery drops the stop request
              if (err_reg) begin
                stop_req_reg <= 1'b0;
              end
            end else if (mst_reg & start_req_i) begin
              rsta_reg  <= 1'b1;
              ph_reg    <= 2'h0;
              state_reg <= ST_START;
            end else if (mst_reg & stop_req_reg) begin
              sda_oe_reg <= 1'b1;    // SDA low before SCL is let up
              ph_reg     <= 2'h0;
              state_reg  <= ST_STOP;
            end else begin
              // Next byte; the slave lets SCL go, the master clocks it
              bitcnt_reg <= 4'h0;
              arm_reg    <= 1'b0;
              scl_oe_reg <= mst_reg;
              sda_oe_reg <= tx_reg & ~data_reg[7];
              if (tx_reg) begin
                shift_reg <= data_reg;
              end
              state_reg <= ST_BYTE;
            end
          end
        end

        ST_BYTE: begin
          // master clock: count only once the line agrees with us
          if (mst_reg & (bitcnt_reg != 4'h9)) begin
            if (scl_oe_reg) begin
              if (filt[1]) begin
                tmr_reg <= 16'h0000;
              end else if (tmr_done) begin
                scl_oe_reg <= 1'b0;
                tmr_reg    <= 16'h0000;
              end else begin
                tmr_reg <= tmr_reg + 16'h0001;
              end
            end else if (~filt[1]) begin
              tmr_reg <= 16'h0000;
            end else if (tmr_done) begin
              scl_oe_reg <= 1'b1;
              tmr_reg    <= 16'h0000;
            end else begin
              tmr_reg <= tmr_reg + 16'h0001;
            end
          end

          if (scl_fall) begin
            if (arm_reg) begin
              arm_reg <= 1'b0;
            end else if (bitcnt_reg < 4'h7) begin
              bitcnt_reg <= bitcnt_reg + 4'h1;
              sda_oe_reg <= tx_reg & ~shift_reg[7];
            end else if (bitcnt_reg == 4'h7) begin
              bitcnt_reg <= 4'h8;
              if (tx_reg) begin
                sda_oe_reg <= 1'b0;
              end else if (first_reg & ~mst_reg) begin
                sda_oe_reg <= adr_own | adr_gc;
                addr_reg   <= adr_own | adr_gc;
                gc_reg     <= adr_gc & ~adr_own;
              end else begin
                sda_oe_reg <= ack_en_i;
              end
            end else if (bitcnt_reg == 4'h8) begin
              // park SCL low unless we are a slave that was never addressed
              bitcnt_reg <= 4'h9;
              sda_oe_reg <= 1'b0;
              scl_oe_reg <= mst_reg | addr_reg;
            end
          end

          if (scl_rise & ~arm_reg) begin
            if (bitcnt_reg < 4'h8) begin
              shift_reg <= {shift_reg[6:0], filt[0]};
              // we let SDA up but the bus reads low
              if (mst_reg & tx_reg & shift_reg[7] & ~filt[0]) begin
                sda_oe_reg     <= 1'b0;
                scl_oe_reg     <= 1'b1;
                mst_reg        <= 1'b0;
                flag_reg       <= 1'b1;
                code_reg       <= `TWSE_ST_ARB_LOST;
                idle_after_reg <= 1'b1;
                state_reg      <= ST_WAIT;
              end
            end else if (bitcnt_reg == 4'h8) begin
              ack_reg <= ~filt[0];   // Low on the ninth clock is ACK
            end
          end

          // one event per byte, raised once SCL is parked
          if (byte_end) begin
            if (first_reg & ~mst_reg & ~addr_reg) begin
              state_reg <= ST_IDLE;  // Someone else's address
            end else if (tx_reg | rxb_ready) begin
              // byte done, flag with its status
              flag_reg       <= 1'b1;
              code_reg       <= end_code;
              first_reg      <= 1'b0;
              idle_after_reg <= ~mst_reg & ~ack_reg & ~first_reg;
              state_reg      <= ST_WAIT;
              if (first_reg) begin
                tx_reg <= mst_reg ^ shift_reg[0];
              end
              if (~tx_reg) begin
                data_reg <= shift_reg;
              end
            end
          end

          if (~arm_reg & (start_det | stop_det) & ~byte_end) begin
            if ((bitcnt_reg != 4'h0) | mst_reg) begin
              err_reg    <= 1'b1;
              flag_reg   <= 1'b1;
              code_reg   <= `TWSE_ST_BUS_ERR;
              sda_oe_reg <= 1'b0;
              scl_oe_reg <= 1'b1;    // Held until recovery lets it go
              mst_reg    <= 1'b0;
              addr_reg   <= 1'b0;
              state_reg  <= ST_WAIT;
            end else if (addr_reg & ~first_reg) begin
              // STOP or repeated START while addressed
              flag_reg       <= 1'b1;
              code_reg       <= `TWSE_ST_SR_STOP;
              idle_after_reg <= 1'b1;
              sda_oe_reg     <= 1'b0;
              scl_oe_reg     <= 1'b1;    // held while flagged
              state_reg      <= ST_WAIT;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end

        default: begin
          state_reg <= ST_IDLE;
        end
      endcase

      // Turning the engine off drops any transfer outside ST_WAIT and lets the lines go
      if (~enable_i & (state_reg != ST_WAIT)) begin
        state_reg  <= ST_IDLE;
        mst_reg    <= 1'b0;
        addr_reg   <= 1'b0;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Received bytes; a full buffer keeps SCL low instead of dropping a byte
  twse_buf2 u_rx_buf (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (rxb_valid),
    .in_data_i   (shift_reg),
    .in_ready_o  (rxb_ready),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // Open-drain pins only ever pull low
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;

  // status word: code in bits 7..3, prescaler in bits 1..0
  assign serial_status_o    = {code_reg[7:3], 1'b0, prescale_i};
  assign serial_data_o      = data_reg;
  assign op_complete_flag_o = flag_reg;
  assign stop_request_o     = stop_req_reg;
  assign bus_busy_o         = busy_reg;

  assign irq_o = flag_reg & serial_irq_enable_i & global_irq_i;

endmodule

/* File: verification/twse_engine_asserts.sv */
// Port checker for the two-wire serial engine
`timescale 1ns/100ps
module twse_chk (
  input wire       ref_clk_i,
  input wire       srst_i,
  input wire       scl_oe_o,
  input wire       sda_oe_o,
  input wire       op_complete_flag_o,
  input wire       stop_request_o,
  input wire [7:0] serial_status_o,
  input wire       irq_o,
  input wire       serial_irq_enable_i,
  input wire       global_irq_i,
  input wire       flag_clear_i,
  input wire       stop_set_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Recovery request: stop pending, error code shown, flag cleared
  wire rcv = op_complete_flag_o & flag_clear_i & stop_request_o & (serial_status_o[7:3] == 5'h00);
  AST_IDLE_CODE: assert property (!op_complete_flag_o |-> serial_status_o[7:3] == 5'h1F)
    else $error("status not idle code");
  AST_SCL_HELD: assert property (op_complete_flag_o [*3] |-> scl_oe_o)
    else $error("scl released while flagged");
  AST_IRQ: assert property (irq_o == (op_complete_flag_o & serial_irq_enable_i & global_irq_i))
    else $error("irq wrong");
  AST_CLEAR: assert property (op_complete_flag_o && flag_clear_i |=> !op_complete_flag_o)
    else $error("flag not cleared");
  AST_KEEP: assert property (op_complete_flag_o && !flag_clear_i |=> op_complete_flag_o)
    else $error("flag dropped alone");
  AST_STOP_SET: assert property ($rose(stop_request_o) |-> $past(stop_set_i))
    else $error("stop request rose alone");
  AST_RCV_STOP: assert property (rcv |=> !stop_request_o)
    else $error("stop request kept");
  AST_RCV_FREE: assert property (rcv |=> ##1 (!scl_oe_o && !sda_oe_o) [*8])
    else $error("lines not released");
endmodule

/* File: verification/twse_slave_model.sv */
// Write-only slave on the bus that acknowledges its own address
`timescale 1ns/100ps
module twse_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire  scl_i,
  input  wire  sda_i,
  output logic sda_oe_o
);
  logic [7:0] shift_reg;
  int         bit_cnt = -1;
  logic       first = 1'b0;
  logic       sel = 1'b0;
  initial sda_oe_o = 1'b0;
  // START opens a frame, STOP closes it
  always @(sda_i) begin
    if (scl_i === 1'b1) begin
      bit_cnt = sda_i ? -1 : 0;
      first = 1'b1;
      sel = 1'b0;
    end
  end
  // Bits sampled while SCL is high
  always @(posedge scl_i) begin
    if (bit_cnt >= 0 && bit_cnt < 8) begin
      shift_reg = {shift_reg[6:0], sda_i};
      bit_cnt = bit_cnt + 1;
    end
  end
  // Acknowledge on the ninth bit only; released at once so the line floats high
  always @(negedge scl_i) begin
    if (bit_cnt == 8) begin
      if (first) sel = (shift_reg[7:1] == ADDR) && !shift_reg[0];
      first = 1'b0;
      sda_oe_o = sel;
      bit_cnt = 9;
    end else if (bit_cnt == 9) begin
      sda_oe_o = 1'b0;
      bit_cnt = 0;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Testbench for the two-wire serial engine
`timescale 1ns/100ps
module tb_top;
  localparam int T = 20;
  logic       clk = 0, srst = 1, sreq = 0, sset = 0, fclr = 0, dwr = 0, rrdy = 0;
  logic       en = 1, sie = 1, gie = 1, tb_scl = 0, tb_sda = 0;
  logic [7:0] din = 8'h00;
  wire        scl_oe, sda_oe, flag, sreq_o, irq, busy, rxv, slv_oe, sclo, sdao;
  wire  [7:0] st, rxd, sdat;
  // Open-drain wires with pull-ups
  wire        scl = ~(scl_oe | tb_scl);
  wire        sda = ~(sda_oe | slv_oe | tb_sda);
  int         mismatches = 0, checks_done = 0, n, m;
  always #2.5 clk = ~clk;
  twse_engine twse_engine_inst (.ref_clk_i(clk), .srst_i(srst), .scl_i(scl), .scl_o(sclo),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sdao), .sda_oe_o(sda_oe), .enable_i(en),
    .start_req_i(sreq), .ack_en_i(1'b1), .gc_enable_i(1'b0), .own_addr_i(7'h2A),
    .bit_rate_divider_i(8'h04), .prescale_i(2'h1), .serial_irq_enable_i(sie),
    .global_irq_i(gie), .stop_set_i(sset), .flag_clear_i(fclr), .data_wr_i(dwr),
    .data_i(din), .op_complete_flag_o(flag), .stop_request_o(sreq_o), .serial_status_o(st),
    .serial_data_o(sdat), .irq_o(irq), .bus_busy_o(busy), .rx_valid_o(rxv), .rx_ready_i(rrdy),
    .rx_data_o(rxd));
  twse_slave_model twse_slave_model_inst (.scl_i(scl), .sda_i(sda), .sda_oe_o(slv_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Software strobes last one cycle; an idle cycle follows so calls never touch
  task automatic sw(input logic w, input logic s, input logic c, input logic [7:0] d);
    {dwr, sset, fclr} = {w, s, c};
    din = d;
    tick(1);
    {dwr, sset, fclr} = 3'h0;
    tick(1);
  endtask
  // software polls the flag rather than waiting on irq
  task automatic wflag(input logic [7:0] code);
    for (int i = 0; i < 5000 && flag !== 1'b1; i++) tick(1);
    chk({7'h00, flag}, 8'h01);
    chk({st[7:3], 3'h0}, code);
  endtask
  task automatic wscl(input logic v, output int k);
    for (k = 0; k < 900 && scl_oe !== v; k++) tick(1);
  endtask
  // Bench as bus master; waits while the engine stretches SCL
  task automatic bb(input logic b);
    tb_sda = ~b;
    tick(T);
    tb_scl = 0;
    for (int i = 0; i < 5000 && scl !== 1'b1; i++) tick(1);
    tick(T);
    tb_scl = 1;
    tick(T);
  endtask
  task automatic tx(input logic [7:0] v);
    for (int k = 7; k >= 0; k--) bb(v[k]);
    bb(1'b1);
  endtask
  // Zero gives START, one gives STOP
  task automatic cond(input logic b);
    tb_sda = b;
    tick(T);
    tb_scl = 0;
    tick(T);
    tb_sda = ~b;
    tick(T);
    tb_scl = ~b;
    tick(T);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    tick(3);
    srst = 0;
    chk(st, 8'hF9);
    chk({4'h0, scl_oe, sda_oe, sclo, sdao}, 8'h00);
    tick(20);
    tb_sda = 1;
    tick(8);
    tb_sda = 0;
    tick(30);
    chk({7'h00, busy}, 8'h00);
    // Master write of one byte to the partner
    sw(1, 0, 0, 8'hA0);
    sreq = 1;
    wflag(8'h08);
    sreq = 0;
    chk({7'h00, irq}, 8'h01);
    gie = 0;
    tick(40);
    chk({6'h00, irq, scl_oe}, 8'h01);
    gie = 1;
    sw(0, 0, 1, 8'h00);
    wscl(0, n);
    wscl(1, n);
    wscl(0, m);
    // Two halves of 8 + 4 << 2 clocks, each plus about 12 clocks of input lag
    chk({7'h00, n + m >= 68 && n + m <= 76}, 8'h01);
    wflag(8'h18);
    sw(1, 0, 0, 8'h5A);
    chk({7'h00, flag}, 8'h01);
    sw(0, 0, 1, 8'h00);
    wflag(8'h28);
    sw(0, 1, 0, 8'h00);
    sw(0, 0, 1, 8'h00);
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) tick(1);
    // Stop request drops only after the STOP hold time has run out
    tick(16);
    chk({5'h00, busy, sreq_o, flag}, 8'h00);
    // Slave receive with the byte sink stalled
    cond(0);
    tx(8'h54);
    wflag(8'h60);
    sw(0, 0, 1, 8'h00);
    tx(8'hA5);
    wflag(8'h80);
    sw(0, 0, 1, 8'h00);
    tx(8'h3C);
    wflag(8'h80);
    chk(sdat, 8'h3C);
    sw(0, 0, 1, 8'h00);
    rrdy = 1;
    chk(rxd, 8'hA5);
    tick(1);
    chk(rxd, 8'h3C);
    tick(1);
    rrdy = 0;
    chk({7'h00, rxv}, 8'h00);
    cond(1);
    wflag(8'hA0);
    sw(0, 0, 1, 8'h00);
    // START inside an address byte, then recovery
    cond(0);
    bb(1);
    bb(0);
    bb(1);
    cond(0);
    wflag(8'h00);
    sw(0, 1, 0, 8'h00);
    chk({7'h00, sreq_o}, 8'h01);
    sw(0, 0, 1, 8'h00);
    tick(2);
    chk({4'h0, flag, sreq_o, scl_oe, sda_oe}, 8'h00);
    cond(1);
    // Arbitration lost on the first address bit, interrupt off so the flag is polled
    // the rival master sends no data bytes, so byte counts cannot differ
    sie = 0;
    sw(1, 0, 0, 8'hA0);
    sreq = 1;
    wflag(8'h08);
    sreq = 0;
    tb_sda = 1;
    sw(0, 0, 1, 8'h00);
    wflag(8'h38);
    chk({6'h00, irq, scl_oe}, 8'h01);
    sw(0, 0, 1, 8'h00);
    tick(T);
    tb_sda = 0;
    tick(T);
    chk({6'h00, busy, scl_oe}, 8'h00);
    close_out();
  end
endmodule
bind twse_engine twse_chk twse_chk_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .op_complete_flag_o(op_complete_flag_o),
  .stop_request_o(stop_request_o), .serial_status_o(serial_status_o), .irq_o(irq_o),
  .serial_irq_enable_i(serial_irq_enable_i), .global_irq_i(global_irq_i),
  .flag_clear_i(flag_clear_i), .stop_set_i(stop_set_i));
